// *** design/izf_pkg.sv ***
package izf_pkg;
  localparam int FIFO_DEPTH = 8;        // Entries in the sample buffer.
  localparam int WORD_W     = 24;       // Bits per stored word.
  localparam int VOLT_W     = 20;       // Voltage field width.
  localparam int VOLT_LSB   = 4;        // Lowest bit of the voltage field.
  localparam int ZERO_BIT   = 3;        // Bit that always reads zero.
  localparam int TAG_W      = 3;        // Tag field width, bits 2..0.
  localparam int CMD_BITS   = 8;        // Address plus read/write bit.
  localparam int FIRST_POP_EDGE = 32;   // Clock rise that ends the first word.
  localparam int BURST_MAX  = 32;       // Words a burst may pop.
  localparam int SCLK_PERIOD_NS = 125;  // Bench period of the serial clock.
  localparam logic [6:0] ADDR_BURST  = 7'h22; // Burst retrieval address.
  localparam logic [6:0] ADDR_SINGLE = 7'h23; // Single-word retrieval address.
  localparam logic [2:0] TAG_VALID     = 3'h0;
  localparam logic [2:0] TAG_RANGE     = 3'h1;
  localparam logic [2:0] TAG_EOF       = 3'h2;
  localparam logic [2:0] TAG_RANGE_EOF = 3'h3;
  localparam logic [2:0] TAG_EMPTY     = 3'h6;
  localparam logic [2:0] TAG_OVF       = 3'h7;
  // Link states, Gray coded along idle, command, data.
  typedef enum logic [1:0] {
    IZF_IDLE = 2'h0,
    IZF_CMD  = 2'h1,
    IZF_DATA = 2'h3
  } izf_link_t;
endpackage

// *** design/izf_sample_fifo.sv ***
// Circular buffer with valid/ready on both sides and a registered ready.
module izf_stream_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       flush,
  input  wire logic                       inValid,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            inReady,
  output logic                            outValid,
  output logic [WIDTH-1:0]                outData,
  input  wire logic                       outReady,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  // Pointers wrap by overflow, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage, indexed by pointer.
    logic [PW-1:0]               wrPtr; // Next slot to write.
    logic [PW-1:0]               rdPtr; // Oldest unread slot.
    logic [LW-1:0]               level; // Unread entries.
    logic                        ready; // Room for one more word.
  } izf_fifo_st_t;
  izf_fifo_st_t s;
  izf_fifo_st_t next_s;
  logic push;
  logic pop;
  // Next-state logic; a flush drops a concurrent write on purpose.
  always_comb begin
    next_s = s;
    push = inValid && s.ready;
    pop = outReady && (s.level != '0);
    if (push) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = s.wrPtr + PW'(1);
    end
    if (pop) begin
      next_s.rdPtr = s.rdPtr + PW'(1);
    end
    unique case ({push, pop})
      2'b10: next_s.level = s.level + LW'(1);
      2'b01: next_s.level = s.level - LW'(1);
      default: next_s.level = s.level;
    endcase
    next_s.ready = (next_s.level != LW'(DEPTH));
    if (flush) begin
      next_s.wrPtr = '0;
      next_s.rdPtr = '0;
      next_s.level = '0;
      next_s.ready = 1'b1;
    end
  end
  // State register; reset clears the storage too.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{ready: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end
  // Ready and level are registered; the head word is read by index.
  assign inReady = s.ready;
  assign outValid = (s.level != '0);
  assign outData = s.mem[s.rdPtr];
  assign level = s.level;
endmodule

// Sample buffer with serial read-out, sampled on the system clock.
module izf_sample_fifo #(
  parameter int DEPTH = izf_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        sampleValid,
  input  wire logic [19:0] sampleVoltage,
  input  wire logic        sampleOutOfRange,
  output logic             sampleReady,
  input  wire logic [2:0]  fifoIrqThreshold,
  input  wire logic        fifoResetCmd,
  input  wire logic        resyncCommand,
  input  wire logic        csbN,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             fifoIrqFlag,
  output logic             fifoOverflowFlag
);
  // The level width must hold the value DEPTH itself.
  localparam int LW = $clog2(DEPTH+1);
  // The threshold code reaches seven, so fewer than eight entries could never raise the flag.
  if (DEPTH < 8) begin : g_chk
    $error("DEPTH must be at least 8");
  end
  typedef struct packed {
    izf_pkg::izf_link_t state;    // Link phase.
    logic [1:0]         csbSync;  // Select synchroniser, bit 0 first.
    logic [2:0]         sclkSync; // Clock synchroniser plus edge history.
    logic [1:0]         sdiSync;  // Data synchroniser.
    logic [4:0]         bitCnt;   // Bit within command or word.
    logic [5:0]         wordCnt;  // Words finished in this frame.
    logic [6:0]         cmdShift; // Command bits taken so far.
    logic               fifoSel;  // Frame reads the buffer.
    logic               burst;    // Frame is a burst read.
    logic               reload;   // Compose the next word this cycle.
    logic [23:0]        shreg;    // Outgoing word.
    logic               sdo;      // Serial output bit.
    logic               ovf;      // Sticky overflow.
    logic               irq;      // Threshold flag.
  } izf_top_st_t;
  izf_top_st_t s;
  izf_top_st_t next_s;
  logic              popNow;
  logic              flush;
  logic              fifoOutValid;
  logic [23:0]       fifoOutData;
  logic [LW-1:0]     fifoLevel;
  logic              rise;
  logic              fall;
  logic [2:0]        tag;
  logic [23:0]       word;
  logic [6:0]        addr;

  assign flush = fifoResetCmd || resyncCommand;
  // Edges are found from the second and third stages only.
  assign rise = s.sclkSync[1] && !s.sclkSync[2];
  assign fall = !s.sclkSync[1] && s.sclkSync[2];

  izf_stream_fifo #(.WIDTH(izf_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .flush           (flush),
    .inValid         (sampleValid),
    .inData          ({sampleVoltage, 3'h0, sampleOutOfRange}),
    .inReady         (sampleReady),
    .outValid        (fifoOutValid),
    .outData         (fifoOutData),
    .outReady        (popNow),
    .level           (fifoLevel)
  );

  // Word composition; overflow outranks empty, empty outranks data tags.
  always_comb begin
    if (s.ovf) begin
      tag = izf_pkg::TAG_OVF;
    end else if (!fifoOutValid) begin
      tag = izf_pkg::TAG_EMPTY;
    end else begin
      tag = {1'b0, fifoLevel == LW'(1), fifoOutData[0]};
    end
    word = {fifoOutValid ? fifoOutData[23:izf_pkg::VOLT_LSB] : 20'h0, 1'b0, tag};
  end

  // Link, overflow and threshold logic.
  always_comb begin
    next_s = s;
    popNow = 1'b0;
    addr = s.cmdShift;
    next_s.csbSync = {s.csbSync[0], csbN};
    next_s.sclkSync = {s.sclkSync[1:0], sclk};
    next_s.sdiSync = {s.sdiSync[0], sdi};
    next_s.reload = 1'b0;
    // Count reaching the threshold code plus one raises the flag.
    next_s.irq = (fifoLevel > LW'(fifoIrqThreshold));
    // An overflow in the same cycle as a clear still wins.
    if (flush) begin
      next_s.ovf = 1'b0;
    end
    if (sampleValid && !sampleReady) begin
      next_s.ovf = 1'b1;
    end
    // The word is latched one cycle after its pop, once the head has moved.
    if (s.reload) begin
      next_s.shreg = word;
    end
    // Deselect ends any frame, even one cut short in mid-word.
    if (s.csbSync[1]) begin
      next_s.state = izf_pkg::IZF_IDLE;
      next_s.bitCnt = '0;
      next_s.wordCnt = '0;
      next_s.fifoSel = 1'b0;
      next_s.sdo = 1'b0;
    end else if (rise) begin
      next_s.bitCnt = s.bitCnt + 5'h1;
      unique case (s.state)
        izf_pkg::IZF_IDLE, izf_pkg::IZF_CMD: begin
          next_s.state = izf_pkg::IZF_CMD;
          next_s.cmdShift = {s.cmdShift[5:0], s.sdiSync[1]};
          if (s.bitCnt == 5'(izf_pkg::CMD_BITS - 1)) begin
            next_s.state = izf_pkg::IZF_DATA;
            next_s.bitCnt = '0;
            // Only reads of the two buffer addresses are served.
            next_s.fifoSel = s.sdiSync[1] && (addr == izf_pkg::ADDR_BURST ||
                                               addr == izf_pkg::ADDR_SINGLE);
            next_s.burst = (addr == izf_pkg::ADDR_BURST);
            next_s.reload = next_s.fifoSel;
            next_s.shreg = '0;
          end
        end
        izf_pkg::IZF_DATA: begin
          if (s.bitCnt == 5'(izf_pkg::WORD_W - 1)) begin
            next_s.bitCnt = '0;
            if (s.wordCnt != 6'(izf_pkg::BURST_MAX)) begin
              next_s.wordCnt = s.wordCnt + 6'h1;
            end
            // Reading an empty buffer moves no pointer.
            if (s.fifoSel && fifoOutValid && (s.burst ?
                s.wordCnt < 6'(izf_pkg::BURST_MAX) : s.wordCnt == '0)) begin
              popNow = 1'b1;
            end
            // A single read shifts zeros after its only word.
            next_s.reload = s.fifoSel && s.burst;
          end
        end
        default: next_s.state = izf_pkg::IZF_IDLE;
      endcase
    end else if (fall && s.state == izf_pkg::IZF_DATA) begin
      // Shifting on the fall lets the host sample a settled bit on the rise.
      next_s.sdo = s.shreg[23];
      next_s.shreg = {s.shreg[22:0], 1'b0};
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '{state: izf_pkg::IZF_IDLE, csbSync: 2'h3, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign sdo = s.sdo;
  assign fifoIrqFlag = s.irq;
  assign fifoOverflowFlag = s.ovf;

  // Checks below run on the system clock and pause while reset is low.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // A word ends at its last data rise while the frame is still selected.
  sequence s_word_end;
    rise && !s.csbSync[1] && s.state == izf_pkg::IZF_DATA &&
      s.bitCnt == 5'(izf_pkg::WORD_W - 1);
  endsequence
  // A sample offered while the buffer is full is lost.
  sequence s_ovf_event;
    sampleValid && !sampleReady;
  endsequence
  property p_pop_at_word_end;
    popNow |-> s_word_end ##0 fifoOutValid;
  endproperty
  a_pop_at_word_end: assert property (p_pop_at_word_end)
    else $error("pop outside a word end");
  property p_single_once;
    popNow && !s.burst |-> s.wordCnt == 6'h0;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("single read popped twice");
  property p_burst_limit;
    popNow |-> s.wordCnt < 6'(izf_pkg::BURST_MAX);
  endproperty
  a_burst_limit: assert property (p_burst_limit)
    else $error("burst popped beyond 32 words");
  // The flag must stand at least two cycles; only a command may drop it.
  property p_ovf_set;
    s_ovf_event |=> fifoOverflowFlag [*2];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged");
  property p_ovf_tag;
    s.reload && s.ovf |=> s.shreg[2:0] == 3'h7;
  endproperty
  a_ovf_tag: assert property (p_ovf_tag)
    else $error("overflow tag missing");
  property p_empty_tag;
    s.reload && !s.ovf && !fifoOutValid |=> s.shreg == 24'h000006;
  endproperty
  a_empty_tag: assert property (p_empty_tag)
    else $error("empty word wrong");
  // Codes 100 and 101 must never leave the block.
  property p_word_shape;
    s.reload |=> !s.shreg[3] && s.shreg[2:1] != 2'h2;
  endproperty
  a_word_shape: assert property (p_word_shape)
    else $error("zero bit or unused tag seen");
  // A command that meets no sample leaves an empty, clean buffer.
  property p_flush_clears;
    flush && !sampleValid |=> fifoLevel == '0 ##1 !fifoOverflowFlag;
  endproperty
  a_flush_clears: assert property (p_flush_clears)
    else $error("reset command left data");
  // The flag follows the level one cycle late, as a registered compare.
  property p_irq_level;
    ##1 fifoIrqFlag == ($past(fifoLevel) > LW'($past(fifoIrqThreshold)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("threshold flag wrong");
endmodule

// *** tb/izf_host_model.sv ***
// Microcontroller model that reads the buffer over the serial link.
module izf_host_model (
  output logic      csbN,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] rx [0:7]; // Words received in the last frame.

  // The serial clock stands still low between frames.
  initial begin
    csbN = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // One read frame: command byte MSB first, then words sampled on each rise.
  // Callers fix the word count, empty reads included; no end tag stops the frame early.
  task automatic frame(input logic [6:0] addr, input int words);
    logic [7:0] cmd;
    cmd = {addr, 1'b1};
    csbN = 1'b0;
    for (int i = 0; i < 8 + 24 * words; i++) begin
      sdi = (i < 8) ? cmd[7-i] : 1'b0;
      #(izf_pkg::SCLK_PERIOD_NS / 2.0) sclk = 1'b1;
      if (i >= 8) begin
        rx[(i-8)/24] = {rx[(i-8)/24][22:0], sdo};
      end
      #(izf_pkg::SCLK_PERIOD_NS / 2.0) sclk = 1'b0;
    end
    #100 csbN = 1'b1;
    #100;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the sample buffer and its serial read-out.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys;          // System clock.
  logic        nrst;             // Active-low reset.
  logic        sampleValid;      // Converter offers a sample.
  logic [19:0] sampleVoltage;    // Sample voltage.
  logic        sampleOutOfRange; // Sample broke the range limits.
  logic        sampleReady;      // Buffer has room.
  logic [2:0]  fifoIrqThreshold; // Threshold code.
  logic        fifoResetCmd;     // Buffer reset command.
  logic        resyncCommand;    // Resynchronise command.
  logic        csbN;             // Serial select.
  logic        sclk;             // Serial clock.
  logic        sdi;              // Serial data in.
  logic        sdo;              // Serial data out.
  logic        fifoIrqFlag;      // Threshold flag.
  logic        fifoOverflowFlag; // Sticky overflow flag.
  int          nFail;            // Mismatches seen.
  int          nChecks;          // Comparisons made.

  izf_sample_fifo izf_sample_fifo_i (
    .clk_sys(clk_sys), .nrst(nrst), .sampleValid(sampleValid),
    .sampleVoltage(sampleVoltage), .sampleOutOfRange(sampleOutOfRange),
    .sampleReady(sampleReady), .fifoIrqThreshold(fifoIrqThreshold),
    .fifoResetCmd(fifoResetCmd), .resyncCommand(resyncCommand), .csbN(csbN),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .fifoIrqFlag(fifoIrqFlag),
    .fifoOverflowFlag(fifoOverflowFlag)
  );
  izf_host_model izf_host_model_i (.csbN(csbN), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  // Free-running 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compares a value seen with its expected value, case-exact.
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Offers one sample for one cycle; inputs change on the falling edge.
  task automatic push(input logic [19:0] v, input logic oor);
    @(negedge clk_sys);
    sampleValid = 1'b1;
    sampleVoltage = v;
    sampleOutOfRange = oor;
    @(negedge clk_sys);
    sampleValid = 1'b0;
  endtask

  // Reads one word at the single address and returns it.
  task automatic read1(output logic [23:0] w);
    izf_host_model_i.frame(izf_pkg::ADDR_SINGLE, 1);
    w = izf_host_model_i.rx[0];
  endtask

  // Empty read gives the empty tag and must not disturb a later sample.
  task automatic t_empty();
    logic [23:0] w;
    read1(w);
    check("empty word", w, 24'h000006);
    izf_host_model_i.frame(7'h10, 1);
    check("other address", izf_host_model_i.rx[0], 24'h000000);
    push(20'h12345, 1'b0);
    read1(w);
    check("after empty", w, {20'h12345, 1'b0, 3'h2});
  endtask

  // Three samples, threshold code two, then single reads drain them in order.
  task automatic t_single();
    logic [23:0] w;
    fifoIrqThreshold = 3'h2;
    push(20'h80001, 1'b0);
    push(20'h7ffff, 1'b1);
    repeat (4) @(negedge clk_sys);
    check("flag below", {23'h0, fifoIrqFlag}, 24'h0);
    push(20'habcde, 1'b0);
    repeat (4) @(negedge clk_sys);
    check("flag at", {23'h0, fifoIrqFlag}, 24'h1);
    read1(w);
    check("word one", w, {20'h80001, 1'b0, 3'h0});
    read1(w);
    check("word two", w, {20'h7ffff, 1'b0, 3'h1});
    read1(w);
    check("word three", w, {20'habcde, 1'b0, 3'h2});
    check("flag drop", {23'h0, fifoIrqFlag}, 24'h0);
  endtask

  // Burst of two words pops each on its own boundary; last is out of range.
  task automatic t_burst();
    push(20'h00f0f, 1'b0);
    push(20'hf0f0f, 1'b1);
    izf_host_model_i.frame(izf_pkg::ADDR_BURST, 2);
    check("burst one", izf_host_model_i.rx[0], {20'h00f0f, 1'b0, 3'h0});
    check("burst two", izf_host_model_i.rx[1], {20'hf0f0f, 1'b0, 3'h3});
  endtask

  // Overflow, then clear by each of the two commands in turn.
  task automatic t_overflow();
    logic [23:0] w;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 9; i++) begin
        push(20'h00100 + 20'(i), 1'b0);
      end
      repeat (3) @(negedge clk_sys);
      check("ovf flag", {23'h0, fifoOverflowFlag}, 24'h1);
      check("full ready", {23'h0, sampleReady}, 24'h0);
      read1(w);
      check("ovf tag", {21'h0, w[2:0]}, 24'h7);
      @(negedge clk_sys);
      if (k == 0) fifoResetCmd = 1'b1;
      else resyncCommand = 1'b1;
      @(negedge clk_sys);
      fifoResetCmd = 1'b0;
      resyncCommand = 1'b0;
      repeat (3) @(negedge clk_sys);
      check("ovf clear", {23'h0, fifoOverflowFlag}, 24'h0);
      read1(w);
      check("cleared", w, 24'h000006);
      push(20'h77777, 1'b0);
      read1(w);
      check("fresh", w, {20'h77777, 1'b0, 3'h2});
    end
  endtask

  // Main sequence: inputs at time zero, ten cycles of reset, then scenarios.
  initial begin
    nFail = 0;
    nChecks = 0;
    nrst = 1'b0;
    sampleValid = 1'b0;
    sampleVoltage = 20'h00000;
    sampleOutOfRange = 1'b0;
    fifoIrqThreshold = 3'h7;
    fifoResetCmd = 1'b0;
    resyncCommand = 1'b0;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_empty();
    t_single();
    t_burst();
    t_overflow();
    report_and_stop();
  end

  // Whole run needs well under 200 us; a hang is cut off here.
  initial begin
    #500000;
    nFail++;
    report_and_stop();
  end
endmodule
